// ### src/iam_pkg.sv
// Shared constants, types and register map of the indirect address mapper
package iam_pkg;

	// Widths
	localparam int PTR_W = 16;
	localparam int DATA_W = 8;
	localparam int ABS_W = 12;
	localparam int FLASH_W = 15;
	localparam int WORD_W = 14;
	localparam int SP_W = 5;
	localparam int BANK_SHIFT = 7;
	localparam int BANK_W = ABS_W - BANK_SHIFT;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	// Pointer regions
	localparam logic [PTR_W-1:0] TRAD_LAST = 16'h0FFF;
	localparam logic [PTR_W-1:0] LIN_BASE = 16'h2000;
	localparam logic [PTR_W-1:0] LIN_LAST = 16'h29AF;
	localparam logic [PTR_W-1:0] GPR_LEN = 16'h0050;
	localparam logic [PTR_W-1:0] GPR_BASE = 16'h0020;
	localparam int FLASH_SEL_BIT = 15;
	localparam int BYTE_HI = 15;
	localparam int BYTE_LO = 8;

	// Offsets of the two port registers inside each bank
	localparam logic [BANK_SHIFT-1:0] PORT0_OFS = 7'h00;
	localparam logic [BANK_SHIFT-1:0] PORT1_OFS = 7'h01;

	// Stack pointer codes
	localparam logic [SP_W-1:0] SP_EMPTY = 5'h1F;
	localparam logic [SP_W-1:0] SP_TOP = 5'h0F;
	localparam logic [SP_W-1:0] SP_BOTTOM = 5'h00;
	localparam logic [SP_W-1:0] SP_ONE = 5'h01;

	// Register byte addresses
	localparam logic [APB_AW-1:0] ADDR_PTR0 = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_PTR1 = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_CONFIG = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [APB_AW-1:0] ADDR_MASK = 8'h10;
	localparam logic [APB_AW-1:0] ADDR_DEPTH = 8'h14;

	// Field positions and reset values
	localparam int CFG_FAULT_EN = 0;
	localparam int STAT_W = 3;
	localparam int ST_OVF = 0;
	localparam int ST_UNF = 1;
	localparam int ST_DROP = 2;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
	localparam logic [APB_DW-1:0] RD_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

	// Region a pointer falls into
	typedef enum logic [1:0] {
		REG_NULL = 2'b00,
		REG_DATA = 2'b01,
		REG_FLASH = 2'b10,
		REG_SELF = 2'b11
	} iam_region_t;

	// Access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_EXTRA = 2'b10,
		ST_WAIT = 2'b11
	} iam_state_t;

	// Decoded target of one pointer
	typedef struct packed {
		iam_region_t region;
		logic [ABS_W-1:0] abs_addr;
		logic [FLASH_W-1:0] flash_addr;
	} iam_map_t;

	// Request toward the banked data memory
	typedef struct packed {
		logic re;
		logic we;
		logic [ABS_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} iam_dmem_t;

endpackage

// ### src/iam_decode.sv
// Pointer decoder: maps a 16-bit pointer onto data memory or flash
`timescale 1ns/1ps
module iam_decode (
	// Pointer in
	input wire logic [iam_pkg::PTR_W-1:0] ptr_i,
	// Decoded target out
	output iam_pkg::iam_map_t map_o
);

	logic [iam_pkg::PTR_W-1:0] lin_off; // Offset into linear region
	logic [iam_pkg::PTR_W-1:0] lin_bank; // Bank of linear offset
	logic [iam_pkg::PTR_W-1:0] lin_byte; // Byte within that bank

	// Constant divisor, so synthesis builds a fixed divider
	always_comb begin
		lin_off = ptr_i - iam_pkg::LIN_BASE;
		// [RQ15] bank and byte split
		lin_bank = lin_off / iam_pkg::GPR_LEN;
		lin_byte = (lin_off % iam_pkg::GPR_LEN) + iam_pkg::GPR_BASE;
	end

	// Region selection, flash half first
	always_comb begin
		map_o.region = iam_pkg::REG_NULL;
		map_o.abs_addr = ptr_i[iam_pkg::ABS_W-1:0];
		map_o.flash_addr = ptr_i[iam_pkg::FLASH_W-1:0];
		if (ptr_i[iam_pkg::FLASH_SEL_BIT]) begin
			// [RQ11] upper half is flash
			map_o.region = iam_pkg::REG_FLASH;
		end else if (ptr_i <= iam_pkg::TRAD_LAST) begin
			// [RQ6] one-to-one banked view
			map_o.region = iam_pkg::REG_DATA;
			// [RQ4] port registers point at nothing
			if (ptr_i[iam_pkg::BANK_SHIFT-1:0] == iam_pkg::PORT0_OFS ||
			    ptr_i[iam_pkg::BANK_SHIFT-1:0] == iam_pkg::PORT1_OFS) begin
				map_o.region = iam_pkg::REG_SELF;
			end
		end else if (ptr_i >= iam_pkg::LIN_BASE &&
		             ptr_i <= iam_pkg::LIN_LAST) begin
			// [RQ7] linear alias of GENERAL_PURPOSE_RAM blocks
			map_o.region = iam_pkg::REG_DATA;
			// [RQ8] [RQ10] banks chained, common skipped
			map_o.abs_addr = {lin_bank[iam_pkg::BANK_W-1:0],
			                  lin_byte[iam_pkg::BANK_SHIFT-1:0]};
		end else begin
			// [RQ16] holes stay unmapped
			map_o.region = iam_pkg::REG_NULL;
		end
	end

endmodule

// ### src/iam_top.sv
// Indirect address mapper with stack fault reset and APB register file
// Function
// [RQ1] Stack over/underflow resets device, sets flag
// [RQ2] Return loads top of stack, then pops
// [RQ3] Port access redirected through its pointer
// [RQ4] Pointer at port: read zero, drop write
// [RQ5] Pointer is high byte joined low byte
// [RQ6] Low 4K maps straight to banked addresses
// [RQ7] 0x2000-0x29AF aliases all GENERAL_PURPOSE_RAM blocks
// [RQ8] Linear bytes run across bank boundaries
// [RQ9] Unimplemented locations read as zero
// [RQ10] Common memory absent from linear region
// [RQ11] Pointer MSB set selects flash address
// [RQ12] Flash read yields low eight bits
// [RQ13] Flash writes through pointer are ignored
// [RQ14] Flash access costs one extra cycle
// [RQ15] Offset divided by eighty gives bank, byte
// [RQ16] Other lower-half pointers read zero
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module iam_top (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [iam_pkg::APB_AW-1:0] PADDR_I,
	input wire logic [iam_pkg::APB_DW-1:0] PWDATA_I,
	output logic [iam_pkg::APB_DW-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Interrupt
	output logic IRQ_O,
	// Indirect access from the core
	input wire logic ACC_REQ_I,
	input wire logic ACC_SEL_I,
	input wire logic ACC_WR_I,
	input wire logic [iam_pkg::DATA_W-1:0] ACC_WDATA_I,
	output logic ACC_ACK_O,
	output logic ACC_BUSY_O,
	output logic [iam_pkg::DATA_W-1:0] ACC_RDATA_O,
	// Banked data memory
	output iam_pkg::iam_dmem_t DMEM_REQ_O,
	input wire logic [iam_pkg::DATA_W-1:0] DMEM_RDATA_I,
	// Program flash read port
	output logic FLASH_RE_O,
	output logic [iam_pkg::FLASH_W-1:0] FLASH_ADDR_O,
	input wire logic [iam_pkg::WORD_W-1:0] FLASH_RDATA_I,
	// Return stack control
	input wire logic PUSH_I,
	input wire logic RET_I,
	input wire logic [iam_pkg::FLASH_W-1:0] TOS_I,
	output logic [iam_pkg::SP_W-1:0] STACK_PTR_O,
	output logic PC_LOAD_O,
	output logic [iam_pkg::FLASH_W-1:0] PC_VALUE_O,
	output logic FAULT_RESET_O
);

	// Register file state
	logic [iam_pkg::PTR_W-1:0] ptr0; // First pointer, high:low bytes
	logic [iam_pkg::PTR_W-1:0] ptr1; // Second pointer
	logic fault_en; // Stack fault reset enable
	logic [iam_pkg::STAT_W-1:0] status; // Sticky event flags
	logic [iam_pkg::STAT_W-1:0] mask; // Interrupt mask
	logic [iam_pkg::STAT_W-1:0] next_status; // Status after this edge
	logic [iam_pkg::STAT_W-1:0] stat_set; // Events of this cycle
	logic [iam_pkg::STAT_W-1:0] stat_clr; // Write-one-to-clear bits

	// APB decode
	logic apb_acc; // Access phase present
	logic apb_wr; // Write takes effect this edge
	logic addr_hit; // Address is mapped
	logic [iam_pkg::APB_DW-1:0] rd_mux; // Read value of addressed reg

	// Access sequencer
	iam_pkg::iam_state_t state; // Sequencer state
	iam_pkg::iam_map_t map; // Decode of selected pointer
	iam_pkg::iam_region_t acc_region; // Region of access in flight
	logic acc_wr; // Access in flight is a write
	logic acc_take; // Core request accepted now
	logic [iam_pkg::PTR_W-1:0] sel_ptr; // Pointer chosen by request

	// Stack events
	logic ovf_evt; // Push past sixteenth level
	logic unf_evt; // Pop past first level
	logic drop_evt; // Indirect write suppressed

	// Pointer chosen by the request picks the target
	always_comb begin
		// [RQ3] port resolves via its pointer
		sel_ptr = ACC_SEL_I ? ptr1 : ptr0;
	end

	// Shared decoder
	iam_decode u_decode (
		.ptr_i(sel_ptr),
		.map_o(map)
	);

	assign acc_take = ACC_REQ_I && (state == iam_pkg::ST_IDLE);

	// APB strobes: one wait state, so read data is registered
	assign apb_acc = PSEL_I && PENABLE_I;
	assign apb_wr = apb_acc && PREADY_O && PWRITE_I && addr_hit;

	// Address decode and read multiplexer, reserved bits zero
	always_comb begin
		addr_hit = 1'b1;
		rd_mux = iam_pkg::RD_ZERO;
		case (PADDR_I)
			iam_pkg::ADDR_PTR0: begin
				rd_mux[iam_pkg::PTR_W-1:0] = ptr0;
			end
			iam_pkg::ADDR_PTR1: begin
				rd_mux[iam_pkg::PTR_W-1:0] = ptr1;
			end
			iam_pkg::ADDR_CONFIG: begin
				rd_mux[iam_pkg::CFG_FAULT_EN] = fault_en;
			end
			iam_pkg::ADDR_STATUS: begin
				rd_mux[iam_pkg::STAT_W-1:0] = status;
			end
			iam_pkg::ADDR_MASK: begin
				rd_mux[iam_pkg::STAT_W-1:0] = mask;
			end
			iam_pkg::ADDR_DEPTH: begin
				rd_mux[iam_pkg::SP_W-1:0] = STACK_PTR_O;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// APB handshake: ready rises one cycle into the access phase
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= iam_pkg::RD_ZERO;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= apb_acc && !PREADY_O;
			if (apb_acc && !PREADY_O) begin
				// Unmapped reads give zero with an error
				PRDATA_O <= PWRITE_I ? iam_pkg::RD_ZERO : rd_mux;
				PSLVERR_O <= !addr_hit;
			end else begin
				PSLVERR_O <= 1'b0;
			end
		end
	end

	// Pointer and control registers written by software
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ptr0 <= iam_pkg::PTR_RST;
			ptr1 <= iam_pkg::PTR_RST;
			fault_en <= 1'b0;
			mask <= iam_pkg::STAT_RST;
		end else if (apb_wr) begin
			case (PADDR_I)
				// [RQ5] high byte over low byte
				iam_pkg::ADDR_PTR0: begin
					ptr0 <= {PWDATA_I[iam_pkg::BYTE_HI:iam_pkg::BYTE_LO],
					         PWDATA_I[iam_pkg::BYTE_LO-1:0]};
				end
				iam_pkg::ADDR_PTR1: begin
					ptr1 <= {PWDATA_I[iam_pkg::BYTE_HI:iam_pkg::BYTE_LO],
					         PWDATA_I[iam_pkg::BYTE_LO-1:0]};
				end
				iam_pkg::ADDR_CONFIG: begin
					fault_en <= PWDATA_I[iam_pkg::CFG_FAULT_EN];
				end
				iam_pkg::ADDR_MASK: begin
					mask <= PWDATA_I[iam_pkg::STAT_W-1:0];
				end
				default: begin
					// Status is handled apart, depth is read-only
				end
			endcase
		end
	end

	// Sticky flags: an event in the clearing cycle survives
	always_comb begin
		stat_set = iam_pkg::STAT_RST;
		stat_set[iam_pkg::ST_OVF] = ovf_evt;
		stat_set[iam_pkg::ST_UNF] = unf_evt;
		stat_set[iam_pkg::ST_DROP] = drop_evt;
		stat_clr = iam_pkg::STAT_RST;
		if (apb_wr && PADDR_I == iam_pkg::ADDR_STATUS) begin
			stat_clr = PWDATA_I[iam_pkg::STAT_W-1:0];
		end
		next_status = (status & ~stat_clr) | stat_set;
	end

	// Status and interrupt output
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			status <= iam_pkg::STAT_RST;
			IRQ_O <= 1'b0;
		end else begin
			status <= next_status;
			IRQ_O <= |(next_status & mask);
		end
	end

	// Stack events; push wins when both strobes come together
	always_comb begin
		// [RQ1] beyond sixteenth or first level
		ovf_evt = fault_en && PUSH_I && (STACK_PTR_O == iam_pkg::SP_TOP);
		unf_evt = fault_en && !PUSH_I && RET_I &&
		          (STACK_PTR_O == iam_pkg::SP_EMPTY);
	end

	// Stack pointer; without the fault reset it simply wraps
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			STACK_PTR_O <= iam_pkg::SP_EMPTY;
			FAULT_RESET_O <= 1'b0;
		end else begin
			FAULT_RESET_O <= ovf_evt || unf_evt;
			if (ovf_evt || unf_evt) begin
				// [RQ1] fault empties the stack
				STACK_PTR_O <= iam_pkg::SP_EMPTY;
			end else if (PUSH_I) begin
				STACK_PTR_O <= (STACK_PTR_O == iam_pkg::SP_TOP) ?
				               iam_pkg::SP_BOTTOM :
				               STACK_PTR_O + iam_pkg::SP_ONE;
			end else if (RET_I) begin
				// [RQ2] pop after the load
				STACK_PTR_O <= (STACK_PTR_O == iam_pkg::SP_EMPTY) ?
				               iam_pkg::SP_TOP :
				               STACK_PTR_O - iam_pkg::SP_ONE;
			end
		end
	end

	// Return loads the program counter from the top entry
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PC_LOAD_O <= 1'b0;
			PC_VALUE_O <= '0;
		end else begin
			// [RQ2] top of stack into PC
			PC_LOAD_O <= RET_I && !PUSH_I && !unf_evt;
			if (RET_I && !PUSH_I && !unf_evt) begin
				PC_VALUE_O <= TOS_I;
			end
		end
	end

	// Sequencer; flash takes the detour through the extra state
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= iam_pkg::ST_IDLE;
			acc_region <= iam_pkg::REG_NULL;
			acc_wr <= 1'b0;
		end else begin
			case (state)
				iam_pkg::ST_IDLE: begin
					if (acc_take) begin
						state <= iam_pkg::ST_ISSUE;
						acc_region <= map.region;
						acc_wr <= ACC_WR_I;
					end
				end
				iam_pkg::ST_ISSUE: begin
					// [RQ14] one added cycle for flash
					state <= (acc_region == iam_pkg::REG_FLASH) ?
					         iam_pkg::ST_EXTRA : iam_pkg::ST_WAIT;
				end
				iam_pkg::ST_EXTRA: begin
					state <= iam_pkg::ST_WAIT;
				end
				iam_pkg::ST_WAIT: begin
					state <= iam_pkg::ST_IDLE;
				end
				default: begin
					state <= iam_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Suppressed writes are flagged so software can spot them
	assign drop_evt = acc_take && ACC_WR_I &&
	                  (map.region != iam_pkg::REG_DATA);

	// Memory strobes, high for the single issue cycle
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DMEM_REQ_O <= '0;
			FLASH_RE_O <= 1'b0;
			FLASH_ADDR_O <= '0;
		end else begin
			DMEM_REQ_O.re <= 1'b0;
			DMEM_REQ_O.we <= 1'b0;
			FLASH_RE_O <= 1'b0;
			if (acc_take) begin
				// [RQ4] [RQ16] no strobe outside data
				DMEM_REQ_O.re <= (map.region == iam_pkg::REG_DATA) &&
				                 !ACC_WR_I;
				DMEM_REQ_O.we <= (map.region == iam_pkg::REG_DATA) &&
				                 ACC_WR_I;
				DMEM_REQ_O.addr <= map.abs_addr;
				DMEM_REQ_O.wdata <= ACC_WDATA_I;
				// [RQ13] flash port is read-only
				FLASH_RE_O <= (map.region == iam_pkg::REG_FLASH) &&
				              !ACC_WR_I;
				FLASH_ADDR_O <= map.flash_addr;
			end
		end
	end

	// Answer to the core, captured as the sequence ends
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ACC_ACK_O <= 1'b0;
			ACC_BUSY_O <= 1'b0;
			ACC_RDATA_O <= iam_pkg::BYTE_ZERO;
		end else begin
			ACC_ACK_O <= (state == iam_pkg::ST_WAIT);
			ACC_BUSY_O <= acc_take || (state == iam_pkg::ST_ISSUE) ||
			              (state == iam_pkg::ST_EXTRA);
			if (state == iam_pkg::ST_WAIT) begin
				if (acc_wr) begin
					ACC_RDATA_O <= iam_pkg::BYTE_ZERO;
				end else if (acc_region == iam_pkg::REG_DATA) begin
					ACC_RDATA_O <= DMEM_RDATA_I;
				end else if (acc_region == iam_pkg::REG_FLASH) begin
					// [RQ12] low byte of program word
					ACC_RDATA_O <= FLASH_RDATA_I[iam_pkg::DATA_W-1:0];
				end else begin
					// [RQ9] [RQ4] nothing behind it reads zero
					ACC_RDATA_O <= iam_pkg::BYTE_ZERO;
				end
			end
		end
	end

endmodule

// ### test/iam_sva.sv
// Port-level checker for the indirect address mapper
`timescale 1ns/1ps
module iam_sva (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// Bus answer
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Core and memory side
	input wire logic ACC_ACK_O,
	input wire logic [iam_pkg::DATA_W-1:0] ACC_RDATA_O,
	input wire iam_pkg::iam_dmem_t DMEM_REQ_O,
	input wire logic FLASH_RE_O,
	input wire logic [iam_pkg::WORD_W-1:0] FLASH_RDATA_I,
	// Stack side
	input wire logic PUSH_I,
	input wire logic RET_I,
	input wire logic [iam_pkg::FLASH_W-1:0] TOS_I,
	input wire logic [iam_pkg::SP_W-1:0] STACK_PTR_O,
	input wire logic PC_LOAD_O,
	input wire logic [iam_pkg::FLASH_W-1:0] PC_VALUE_O,
	input wire logic FAULT_RESET_O
);
	// Single clock domain
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// A pop that has an entry to take
	wire logic pop_ok;
	assign pop_ok = RET_I && !PUSH_I && STACK_PTR_O != iam_pkg::SP_EMPTY;
	data_lat_a: assert property (DMEM_REQ_O.re |-> ##2 ACC_ACK_O)
		else $error("data ack not two cycles after strobe");
	flash_lat_a: assert property (FLASH_RE_O |-> ##3 ACC_ACK_O)
		else $error("flash ack not three cycles after strobe");
	flash_byte_a: assert property (FLASH_RE_O |->
		##3 ACC_RDATA_O == FLASH_RDATA_I[7:0])
		else $error("flash byte mismatch");
	flash_only_a: assert property (FLASH_RE_O |->
		!(DMEM_REQ_O.re || DMEM_REQ_O.we) [*3])
		else $error("data strobe during flash access");
	pc_load_a: assert property (pop_ok |=>
		PC_LOAD_O && PC_VALUE_O == $past(TOS_I))
		else $error("return did not load saved address");
	pop_step_a: assert property (pop_ok |=>
		STACK_PTR_O == $past(STACK_PTR_O) - 5'h01)
		else $error("return did not pop one level");
	fault_cause_a: assert property (FAULT_RESET_O |->
		$past(PUSH_I && STACK_PTR_O == iam_pkg::SP_TOP ||
		RET_I && STACK_PTR_O == iam_pkg::SP_EMPTY))
		else $error("fault reset without stack fault");
	fault_empty_a: assert property (FAULT_RESET_O |->
		STACK_PTR_O == iam_pkg::SP_EMPTY ##1 !FAULT_RESET_O)
		else $error("fault reset not a pulse to empty");
	// Ack pulse stands one cycle; error comes only with ready
	ack_pulse_a: assert property (ACC_ACK_O |=> !ACC_ACK_O)
		else $error("ack longer than one cycle");
	err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	// Main scenarios
	cover property (FLASH_RE_O ##3 ACC_ACK_O);
	cover property (FAULT_RESET_O);
	cover property (PSLVERR_O);
endmodule
bind iam_top iam_sva i_iam_sva (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ACC_ACK_O(ACC_ACK_O),
	.ACC_RDATA_O(ACC_RDATA_O), .DMEM_REQ_O(DMEM_REQ_O),
	.FLASH_RE_O(FLASH_RE_O), .FLASH_RDATA_I(FLASH_RDATA_I),
	.PUSH_I(PUSH_I), .RET_I(RET_I), .TOS_I(TOS_I),
	.STACK_PTR_O(STACK_PTR_O), .PC_LOAD_O(PC_LOAD_O),
	.PC_VALUE_O(PC_VALUE_O), .FAULT_RESET_O(FAULT_RESET_O));

// ### test/iam_mem_model.sv
// Data memory and program flash model facing the mapper
`timescale 1ns/1ps
module iam_mem_model (
	// Clock
	input wire logic clk_i,
	// Data memory port
	input wire iam_pkg::iam_dmem_t dmem_i,
	output logic [iam_pkg::DATA_W-1:0] dmem_rdata_o = 8'h00,
	// Flash read port
	input wire logic flash_re_i,
	input wire logic [iam_pkg::FLASH_W-1:0] flash_addr_i,
	output logic [iam_pkg::WORD_W-1:0] flash_rdata_o = 14'h0000
);
	// Banked bytes, seeded so every address holds a known value
	logic [iam_pkg::DATA_W-1:0] mem [4096];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	// Read byte valid only in the cycle after the strobe; it toggles
	// otherwise so a late capture cannot look right by chance
	always @(posedge clk_i) begin
		if (dmem_i.re) begin
			dmem_rdata_o <= mem[dmem_i.addr];
		end else begin
			dmem_rdata_o <= ~dmem_rdata_o;
		end
		if (dmem_i.we) begin
			mem[dmem_i.addr] <= dmem_i.wdata;
		end
	end
	// Flash word held until the next strobe; high bits differ from low
	always @(posedge clk_i) begin
		if (flash_re_i) begin
			flash_rdata_o <= {flash_addr_i[5:0], ~flash_addr_i[7:0]};
		end
	end
endmodule

// ### test/iam_top_bench.sv
// Self-checking bench for the indirect address mapper
`timescale 1ns/1ps
module iam_top_bench;
	// Stimulus
	logic clk, rst_n, psel, penable, pwrite, acc_req, acc_sel, acc_wr;
	logic push, ret;
	logic [7:0] paddr, acc_wdata;
	logic [31:0] pwdata;
	logic [14:0] tos;
	// Observed
	logic [31:0] prdata;
	logic pready, pslverr, irq, acc_ack, flash_re, pc_load, fault, busy;
	logic [7:0] acc_rdata, dmem_rdata;
	logic [14:0] pc_value, flash_addr;
	logic [13:0] flash_rdata;
	logic [4:0] sp;
	iam_pkg::iam_dmem_t dmem_req;
	int miscompares, n_compared;
	iam_top i_iam_top (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .IRQ_O(irq), .ACC_REQ_I(acc_req),
		.ACC_SEL_I(acc_sel), .ACC_WR_I(acc_wr), .ACC_WDATA_I(acc_wdata),
		.ACC_ACK_O(acc_ack), .ACC_BUSY_O(busy), .ACC_RDATA_O(acc_rdata),
		.DMEM_REQ_O(dmem_req), .DMEM_RDATA_I(dmem_rdata),
		.FLASH_RE_O(flash_re), .FLASH_ADDR_O(flash_addr),
		.FLASH_RDATA_I(flash_rdata), .PUSH_I(push), .RET_I(ret),
		.TOS_I(tos), .STACK_PTR_O(sp), .PC_LOAD_O(pc_load),
		.PC_VALUE_O(pc_value), .FAULT_RESET_O(fault));
	iam_mem_model i_iam_mem_model (.clk_i(clk), .dmem_i(dmem_req),
		.dmem_rdata_o(dmem_rdata), .flash_re_i(flash_re),
		.flash_addr_i(flash_addr), .flash_rdata_o(flash_rdata));
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Count a comparison, report a mismatch
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One APB transfer; the request stands until the rising edge at
	// which ready is seen high, and the answer is taken at that edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(n, 2);
		r = {prdata[31:1], prdata[0] | pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One core access; n counts edges from take to the answering edge,
	// nb the cycles in which busy stood before the answer
	task automatic acc(input logic s, input logic w, input logic [7:0] d,
		output logic [7:0] r, output int n);
		int nb;
		@(posedge clk);
		acc_req <= 1'b1;
		acc_sel <= s;
		acc_wr <= w;
		acc_wdata <= d;
		@(posedge clk);
		acc_req <= 1'b0;
		n = 0;
		nb = 0;
		do begin
			@(posedge clk);
			n++;
			nb += int'(busy === 1'b1);
		end while (acc_ack !== 1'b1 && n < 20);
		r = acc_rdata;
		// Busy covers every cycle after the take except the answer
		chk(nb, n - 1);
	endtask
	// One push or return pulse, then settle past the answering edge
	task automatic stk(input logic p, input logic [14:0] v);
		@(posedge clk);
		push <= p;
		ret <= !p;
		tos <= v;
		@(posedge clk);
		push <= 1'b0;
		ret <= 1'b0;
		@(negedge clk);
	endtask
	// Reset values, pointer halves joined, unmapped address flagged
	task automatic t_regs();
		logic [31:0] r;
		apb(1'b0, iam_pkg::ADDR_DEPTH, '0, r);
		chk(r, 32'h0000_001F);
		apb(1'b1, iam_pkg::ADDR_PTR1, 32'h0000_1234, r);
		apb(1'b0, iam_pkg::ADDR_PTR1, '0, r);
		chk(r, 32'h0000_1234);
		apb(1'b0, 8'h18, '0, r);
		chk(r, 32'h0000_0001);
	endtask
	// Traditional and linear mappings, including bank seams
	task automatic t_map();
		logic [15:0] p [5] = '{16'h0123, 16'h2000, 16'h204F, 16'h2050,
			16'h29AF};
		logic [11:0] a [5] = '{12'h123, 12'h020, 12'h06F, 12'h0A0,
			12'hF6F};
		logic [31:0] r;
		logic [7:0] b;
		int n;
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, iam_pkg::ADDR_PTR1, {16'h0000, p[i]}, r);
			acc(1'b1, 1'b1, 8'hC0 + 8'(i), b, n);
			chk(i_iam_mem_model.mem[a[i]], 8'hC0 + 8'(i));
			acc(1'b1, 1'b0, 8'h00, b, n);
			chk(b, 8'hC0 + 8'(i));
			chk(n, 3);
		end
	endtask
	// Holes and the port itself read zero; suppressed write raises irq
	task automatic t_holes();
		logic [15:0] p [4] = '{16'h1000, 16'h29B0, 16'h7FFF, 16'h0081};
		logic [31:0] r;
		logic [7:0] b;
		int n;
		apb(1'b1, iam_pkg::ADDR_MASK, '0, r);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, iam_pkg::ADDR_PTR0, {16'h0000, p[i]}, r);
			acc(1'b0, 1'b0, 8'h00, b, n);
			chk(b, 8'h00);
		end
		acc(1'b0, 1'b1, 8'h77, b, n);
		chk(i_iam_mem_model.mem[12'h081], 8'hDB);
		apb(1'b0, iam_pkg::ADDR_STATUS, '0, r);
		chk(r, 32'h0000_0004);
		chk(irq, 1'b0);
		apb(1'b1, iam_pkg::ADDR_MASK, 32'h0000_0004, r);
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		apb(1'b1, iam_pkg::ADDR_STATUS, 32'h0000_0004, r);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
	endtask
	// Flash reads give the low byte one cycle late; writes are dropped
	task automatic t_flash();
		logic [31:0] r;
		logic [7:0] b;
		int n;
		apb(1'b1, iam_pkg::ADDR_PTR0, 32'h0000_8123, r);
		acc(1'b0, 1'b0, 8'h00, b, n);
		chk({flash_addr, b}, {15'h0123, 8'hDC});
		chk(n, 4);
		acc(1'b0, 1'b1, 8'h55, b, n);
		chk(n, 4);
		chk(i_iam_mem_model.mem[12'h123], 8'hC0);
		apb(1'b0, iam_pkg::ADDR_STATUS, '0, r);
		chk(r, 32'h0000_0004);
		apb(1'b1, iam_pkg::ADDR_STATUS, 32'h0000_0007, r);
	endtask
	// Return loads and pops; overflow and underflow reset with flags
	task automatic t_stack();
		logic [31:0] r;
		// Fault reset off: pointer wraps both ways, no fault pulse
		stk(1'b0, 15'h0123);
		chk({fault, pc_load, pc_value, sp}, {2'b01, 15'h0123, 5'h0F});
		stk(1'b1, 15'h0000);
		chk({fault, sp}, {1'b0, 5'h00});
		stk(1'b0, 15'h0000);
		chk({fault, sp}, {1'b0, 5'h1F});
		apb(1'b1, iam_pkg::ADDR_CONFIG, 32'h0000_0001, r);
		repeat (16) stk(1'b1, 15'h0000);
		stk(1'b0, 15'h1ABC);
		chk({pc_load, pc_value, sp}, {1'b1, 15'h1ABC, 5'h0E});
		stk(1'b1, 15'h0000);
		stk(1'b1, 15'h0000);
		chk({fault, sp}, {1'b1, 5'h1F});
		apb(1'b0, iam_pkg::ADDR_STATUS, '0, r);
		chk(r, 32'h0000_0001);
		apb(1'b1, iam_pkg::ADDR_STATUS, 32'h0000_0007, r);
		stk(1'b0, 15'h0555);
		chk({fault, pc_load, sp}, {2'b10, 5'h1F});
		apb(1'b0, iam_pkg::ADDR_STATUS, '0, r);
		chk(r, 32'h0000_0002);
	endtask
	// Verdict and end of run
	task automatic give_verdict();
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, acc_req, acc_sel, acc_wr} = '0;
		{push, ret, paddr, acc_wdata, pwdata, tos} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_map();
		t_holes();
		t_flash();
		t_stack();
		give_verdict();
	end
	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule
